// *** fb_port_cfg.svh ***
// Constants for the framebuffer memory port
`ifndef FB_PORT_CFG_SVH
`define FB_PORT_CFG_SVH
`define FB_DATA_W 128
`define FB_ADDR_W 11
`define FB_LANES 16
`define FB_BANKS 2
`define ROM_ADDR_LSB 0
`define ROM_ADDR_W 16
`define ROM_OE_BIT 16
`define ROM_WE_BIT 17
`define ROM_BYTE_LSB 24
`define ROM_BYTE_W 8
`define ROM_SHARED_W 32
`define ROM_PULSE_NS 150
`define SYS_PERIOD_NS 50
`define ROM_PULSE_CYC ((`ROM_PULSE_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define STRAP_W 10
`endif

// *** fb_port_pkg.sv ***
// Types for the framebuffer memory port
package fb_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RAM_REQ = 3'b001,
		ST_RAM_WAIT = 3'b010,
		ST_ROM_SETUP = 3'b011,
		ST_ROM_STROBE = 3'b100,
		ST_ROM_HOLD = 3'b101
	} port_state_e;
	typedef logic [3:0] rom_cnt_t;
endpackage : fb_port_pkg

// *** fb_port.sv ***
// Framebuffer memory port: SGRAM command pins, forwarded clocks, shared boot ROM access
`include "fb_port_cfg.svh"

// Behaviour
// RULE1 - 128-bit two-way memory data bus
// RULE2 - low 32 data lines reach byte ROM
// RULE3 - ROM address on 15:0, byte 31:24
// RULE4 - ROM write on 17, enable on 16
// RULE5 - dedicated active-low ROM chip select
// RULE6 - 11-bit address, straps sampled during host reset
// RULE7 - top address line reserved, unused
// RULE8 - shared row, column, write strobes
// RULE9 - one chip select per bank
// RULE10 - sixteen byte mask lines
// RULE11 - per-bank clock plus loopback copy
// RULE12 - board loops third clock back in
// RULE13 - clock enable output reserved, unused
// RULE14 - ROM and RAM never overlap
module fb_port (
	// System
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic host_reset_n,
	// Memory clock domain
	input wire logic fb_mem_clk,
	input wire logic fb_clock_return,
	// RAM command request, sys_clk domain
	input wire logic ram_req,
	output logic ram_busy,
	output logic ram_done,
	input wire logic [`FB_BANKS-1:0] ram_bank,
	input wire logic ram_row_strobe,
	input wire logic ram_col_strobe,
	input wire logic ram_write_strobe,
	input wire logic [`FB_ADDR_W-2:0] ram_addr,
	input wire logic [`FB_LANES-1:0] ram_mask,
	input wire logic ram_drive,
	input wire logic [`FB_DATA_W-1:0] ram_wdata,
	output logic [`FB_DATA_W-1:0] ram_rdata,
	// ROM request
	input wire logic rom_req,
	input wire logic rom_write,
	input wire logic [`ROM_ADDR_W-1:0] rom_addr,
	input wire logic [`ROM_BYTE_W-1:0] rom_wbyte,
	output logic rom_busy,
	output logic rom_done,
	output logic [`ROM_BYTE_W-1:0] rom_rbyte,
	// Strap values
	output logic [`STRAP_W-1:0] strap_value,
	// Memory pins
	input wire logic [`FB_DATA_W-1:0] fb_data_bus_i,
	output logic [`FB_DATA_W-1:0] fb_data_bus_o,
	output logic [`FB_DATA_W-1:0] fb_data_bus_oe,
	output logic [`FB_ADDR_W-1:0] fb_addr_bus,
	input wire logic [`FB_ADDR_W-1:0] fb_addr_bus_i,
	output logic [`FB_ADDR_W-1:0] fb_addr_bus_oe,
	output logic fb_row_strobe_n,
	output logic fb_col_strobe_n,
	output logic fb_write_strobe_n,
	output logic [`FB_BANKS-1:0] fb_bank_select_n,
	output logic [`FB_LANES-1:0] fb_byte_mask,
	output logic fb_bank0_clock,
	output logic fb_bank1_clock,
	output logic fb_loopback_clock,
	output logic fb_clock_gate,
	output logic boot_rom_select_n
);
	import fb_port_pkg::*;

	port_state_e state_ff;
	port_state_e nxt_state;
	rom_cnt_t rom_cnt_ff;
	logic rom_write_ff;
	logic [`ROM_ADDR_W-1:0] rom_addr_ff;
	logic [`ROM_BYTE_W-1:0] rom_wbyte_ff;
	logic [`ROM_BYTE_W-1:0] rom_rbyte_ff;
	logic rom_done_ff;
	logic ram_done_ff;
	logic [`STRAP_W-1:0] strap_ff;
	logic [2:0] hrst_sync_ff;
	logic hrst_on_ff;
	logic hrst_asserted;

	// RAM command capture, sys_clk side; held stable while the toggle crosses
	logic [`FB_BANKS-1:0] cmd_bank_ff;
	logic cmd_ras_ff;
	logic cmd_cas_ff;
	logic cmd_we_ff;
	logic [`FB_ADDR_W-2:0] cmd_addr_ff;
	logic [`FB_LANES-1:0] cmd_mask_ff;
	logic cmd_drive_ff;
	logic [`FB_DATA_W-1:0] cmd_wdata_ff;
	logic req_tgl_ff;
	logic [1:0] ack_sync_ff;
	logic ack_seen_ff;
	logic [`FB_DATA_W-1:0] ram_rdata_ff;

	// Memory clock side
	logic [1:0] req_sync_ff;
	logic req_seen_ff;
	logic mem_ack_tgl_ff;
	logic mem_issue_ff;
	logic mem_issue2_ff;
	logic [`FB_DATA_W-1:0] mem_rdata_ff;
	logic [`FB_BANKS-1:0] mem_cs_n_ff;
	logic mem_ras_n_ff;
	logic mem_cas_n_ff;
	logic mem_we_n_ff;
	logic [`FB_ADDR_W-1:0] mem_addr_ff;
	logic [`FB_LANES-1:0] mem_mask_ff;
	logic mem_drive_ff;
	logic [`FB_DATA_W-1:0] mem_wdata_ff;

	// Straps: host reset comes from a pin, three stages, a change counts once the last two agree
	// Address bus is released while host reset holds so the board resistors set the straps
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hrst_sync_ff <= 3'h0;
			hrst_on_ff <= 1'b1;
			strap_ff <= '0;
		end else begin
			hrst_sync_ff <= {hrst_sync_ff[1:0], host_reset_n};
			if (hrst_sync_ff[1] == hrst_sync_ff[2]) begin
				hrst_on_ff <= !hrst_sync_ff[2];
			end
			if (hrst_on_ff) begin
				strap_ff <= fb_addr_bus_i[`STRAP_W-1:0]; // RULE6
			end
		end
	end
	assign hrst_asserted = hrst_on_ff;
	assign strap_value = strap_ff;

	// Arbitration: one owner of the shared low lines at a time
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (!hrst_asserted && rom_req) begin
					nxt_state = ST_ROM_SETUP; // RULE14
				end else if (!hrst_asserted && ram_req) begin
					nxt_state = ST_RAM_REQ;
				end
			end
			ST_RAM_REQ: nxt_state = ST_RAM_WAIT;
			ST_RAM_WAIT: begin
				if (ack_sync_ff[1] != ack_seen_ff) begin
					nxt_state = ST_IDLE; // RULE14
				end
			end
			ST_ROM_SETUP: nxt_state = ST_ROM_STROBE;
			ST_ROM_STROBE: begin
				if (rom_cnt_ff == rom_cnt_t'(`ROM_PULSE_CYC - 1)) begin
					nxt_state = ST_ROM_HOLD;
				end
			end
			ST_ROM_HOLD: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rom_cnt_ff <= '0;
		end else if (state_ff == ST_ROM_STROBE) begin
			rom_cnt_ff <= rom_cnt_ff + rom_cnt_t'(1);
		end else begin
			rom_cnt_ff <= '0;
		end
	end

	// ROM request capture; only read inside a ROM phase, so no reset
	always_ff @(posedge sys_clk) begin
		if (state_ff == ST_IDLE && !hrst_asserted && rom_req) begin
			rom_write_ff <= rom_write;
			rom_addr_ff <= rom_addr;
			rom_wbyte_ff <= rom_wbyte;
		end
	end

	// Read byte taken at end of strobe, not on the asynchronous edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rom_rbyte_ff <= '0;
		end else if (state_ff == ST_ROM_STROBE && nxt_state == ST_ROM_HOLD && !rom_write_ff) begin
			rom_rbyte_ff <= fb_data_bus_i[`ROM_BYTE_LSB +: `ROM_BYTE_W]; // RULE3
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rom_done_ff <= 1'b0;
			ram_done_ff <= 1'b0;
			ram_rdata_ff <= '0;
		end else begin
			rom_done_ff <= state_ff == ST_ROM_HOLD;
			ram_done_ff <= state_ff == ST_RAM_WAIT && nxt_state == ST_IDLE;
			// Read word stable by the time the ack toggle has crossed
			if (state_ff == ST_RAM_WAIT && nxt_state == ST_IDLE) begin
				ram_rdata_ff <= mem_rdata_ff;
			end
		end
	end
	assign ram_rdata = ram_rdata_ff;
	assign rom_done = rom_done_ff;
	assign rom_rbyte = rom_rbyte_ff;
	assign ram_done = ram_done_ff;
	assign rom_busy = state_ff != ST_IDLE;
	assign ram_busy = state_ff != ST_IDLE;

	// RAM command hand-off to the memory clock by toggle
	always_ff @(posedge sys_clk) begin
		if (state_ff == ST_IDLE && nxt_state == ST_RAM_REQ) begin
			cmd_bank_ff <= ram_bank;
			cmd_ras_ff <= ram_row_strobe;
			cmd_cas_ff <= ram_col_strobe;
			cmd_we_ff <= ram_write_strobe;
			cmd_addr_ff <= ram_addr; // RULE7
			cmd_mask_ff <= ram_mask;
			cmd_drive_ff <= ram_drive;
			cmd_wdata_ff <= ram_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			req_tgl_ff <= 1'b0;
			ack_sync_ff <= 2'h0;
			ack_seen_ff <= 1'b0;
		end else begin
			if (state_ff == ST_RAM_REQ) begin
				req_tgl_ff <= !req_tgl_ff;
			end
			ack_sync_ff <= {ack_sync_ff[0], mem_ack_tgl_ff};
			ack_seen_ff <= ack_sync_ff[1];
		end
	end

	// Memory clock domain: one command cycle, then one cycle to capture read data
	always_ff @(posedge fb_mem_clk or negedge nrst) begin
		if (!nrst) begin
			req_sync_ff <= 2'h0;
			req_seen_ff <= 1'b0;
			mem_issue_ff <= 1'b0;
			mem_issue2_ff <= 1'b0;
			mem_ack_tgl_ff <= 1'b0;
		end else begin
			req_sync_ff <= {req_sync_ff[0], req_tgl_ff};
			req_seen_ff <= req_sync_ff[1];
			mem_issue_ff <= req_sync_ff[1] != req_seen_ff;
			mem_issue2_ff <= mem_issue_ff;
			if (mem_issue2_ff) begin
				mem_ack_tgl_ff <= !mem_ack_tgl_ff;
			end
		end
	end

	always_ff @(posedge fb_mem_clk or negedge nrst) begin
		if (!nrst) begin
			mem_cs_n_ff <= '1;
			mem_ras_n_ff <= 1'b1;
			mem_cas_n_ff <= 1'b1;
			mem_we_n_ff <= 1'b1;
			mem_addr_ff <= '0;
			mem_mask_ff <= '1;
			mem_drive_ff <= 1'b0;
			mem_wdata_ff <= '0;
		end else if (req_sync_ff[1] != req_seen_ff) begin
			mem_cs_n_ff <= ~cmd_bank_ff; // RULE9
			mem_ras_n_ff <= !cmd_ras_ff; // RULE8
			mem_cas_n_ff <= !cmd_cas_ff;
			mem_we_n_ff <= !cmd_we_ff;
			mem_addr_ff <= {1'b0, cmd_addr_ff}; // RULE7
			mem_mask_ff <= cmd_mask_ff; // RULE10
			mem_drive_ff <= cmd_drive_ff;
			mem_wdata_ff <= cmd_wdata_ff;
		end else begin
			mem_cs_n_ff <= '1;
			mem_ras_n_ff <= 1'b1;
			mem_cas_n_ff <= 1'b1;
			mem_we_n_ff <= 1'b1;
			mem_drive_ff <= 1'b0;
		end
	end

	// Read data returns on the loopback clock; sampled here a cycle after the command
	always_ff @(posedge fb_mem_clk or negedge nrst) begin
		if (!nrst) begin
			mem_rdata_ff <= '0;
		end else if (mem_issue_ff) begin
			mem_rdata_ff <= fb_data_bus_i;
		end
	end

	// Pin drive: ROM owns the low 32 lines only outside RAM cycles
	logic rom_phase;
	assign rom_phase = state_ff == ST_ROM_SETUP || state_ff == ST_ROM_STROBE || state_ff == ST_ROM_HOLD;
	always_comb begin
		fb_data_bus_o = mem_wdata_ff; // RULE1
		fb_data_bus_oe = {`FB_DATA_W{mem_drive_ff}};
		if (rom_phase) begin
			fb_data_bus_o[`ROM_SHARED_W-1:0] = '0; // RULE2
			fb_data_bus_oe[`ROM_SHARED_W-1:0] = '0;
			fb_data_bus_o[`ROM_ADDR_LSB +: `ROM_ADDR_W] = rom_addr_ff; // RULE3
			fb_data_bus_oe[`ROM_ADDR_LSB +: `ROM_ADDR_W] = '1;
			fb_data_bus_o[`ROM_OE_BIT] = !(state_ff == ST_ROM_STROBE && !rom_write_ff); // RULE4
			fb_data_bus_o[`ROM_WE_BIT] = !(state_ff == ST_ROM_STROBE && rom_write_ff);
			fb_data_bus_oe[`ROM_OE_BIT] = 1'b1;
			fb_data_bus_oe[`ROM_WE_BIT] = 1'b1;
			fb_data_bus_o[`ROM_BYTE_LSB +: `ROM_BYTE_W] = rom_wbyte_ff;
			fb_data_bus_oe[`ROM_BYTE_LSB +: `ROM_BYTE_W] = {`ROM_BYTE_W{rom_write_ff}};
		end
	end

	// Drivers off while host reset holds so straps can be read
	assign fb_addr_bus = mem_addr_ff;
	assign fb_addr_bus_oe = {`FB_ADDR_W{!hrst_asserted}}; // RULE6
	assign fb_row_strobe_n = mem_ras_n_ff;
	assign fb_col_strobe_n = mem_cas_n_ff;
	assign fb_write_strobe_n = mem_we_n_ff;
	assign fb_bank_select_n = mem_cs_n_ff;
	assign fb_byte_mask = mem_mask_ff;
	assign boot_rom_select_n = !rom_phase; // RULE5

	// Forwarded clocks; fb_clock_return is only a reference for board timing
	assign fb_bank0_clock = fb_mem_clk; // RULE11
	assign fb_bank1_clock = fb_mem_clk;
	assign fb_loopback_clock = fb_mem_clk; // RULE12
	assign fb_clock_gate = 1'b1; // RULE13
endmodule : fb_port

// *** fb_port_monitor.sv ***
// Pin checker for the framebuffer memory port
`include "fb_port_cfg.svh"
module fb_port_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Watched outputs
	input wire logic rom_done,
	input wire logic boot_rom_select_n,
	input wire logic [`FB_DATA_W-1:0] fb_data_bus_o,
	input wire logic [`FB_DATA_W-1:0] fb_data_bus_oe,
	input wire logic [`FB_ADDR_W-1:0] fb_addr_bus,
	input wire logic [`FB_BANKS-1:0] fb_bank_select_n,
	input wire logic fb_bank0_clock,
	input wire logic fb_bank1_clock,
	input wire logic fb_loopback_clock,
	input wire logic fb_clock_gate
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_rom_pins; !boot_rom_select_n |-> &fb_data_bus_oe[17:0]; endproperty
	a_rom_pins: assert property (p_rom_pins)
		else $error("ROM address or strobe lines not driven");
	property p_rom_strobe;
		$fell(boot_rom_select_n) |-> (fb_data_bus_o[16] && fb_data_bus_o[17])
			##1 (fb_data_bus_o[16] ^ fb_data_bus_o[17]) [*3] ##1 (fb_data_bus_o[16] && fb_data_bus_o[17]);
	endproperty
	a_rom_strobe: assert property (p_rom_strobe)
		else $error("ROM strobe shape wrong");
	property p_rom_done; $fell(boot_rom_select_n) |-> ##5 (rom_done && boot_rom_select_n); endproperty
	a_rom_done: assert property (p_rom_done)
		else $error("ROM access length wrong");
	property p_no_overlap; !boot_rom_select_n |-> &fb_bank_select_n; endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("RAM bank selected during ROM access");
	property p_top_addr; fb_addr_bus[10] == 1'b0; endproperty
	a_top_addr: assert property (p_top_addr)
		else $error("Top address line used");
	property p_gate; fb_clock_gate == 1'b1; endproperty
	a_gate: assert property (p_gate)
		else $error("Clock enable output moved");
	property p_clocks; fb_bank0_clock == fb_bank1_clock && fb_bank1_clock == fb_loopback_clock; endproperty
	a_clocks: assert property (p_clocks)
		else $error("Forwarded clocks differ");
	property p_one_bank; $countones(~fb_bank_select_n) <= 1; endproperty
	a_one_bank: assert property (p_one_bank)
		else $error("Both banks selected");
	c_rom: cover property ($fell(boot_rom_select_n));
	c_bank0: cover property (!fb_bank_select_n[0]);
	c_bank1: cover property (!fb_bank_select_n[1]);
endmodule : fb_port_monitor

bind fb_port fb_port_monitor u_mon (.*);

// *** fb_board_model.sv ***
// Board model: strap resistors, boot ROM and loopback trace
`include "fb_port_cfg.svh"
module fb_board_model #(parameter logic [`STRAP_W-1:0] STRAP = 10'h2A5) (
	// Clocks
	input wire logic sys_clk,
	input wire logic fb_loopback_clock,
	output logic fb_clock_return,
	// Pins
	input wire logic boot_rom_select_n,
	input wire logic [`FB_DATA_W-1:0] fb_data_bus_o,
	input wire logic [`FB_DATA_W-1:0] fb_data_bus_oe,
	output logic [`FB_DATA_W-1:0] fb_data_bus_i,
	input wire logic [`FB_ADDR_W-1:0] fb_addr_bus,
	input wire logic [`FB_ADDR_W-1:0] fb_addr_bus_oe,
	output logic [`FB_ADDR_W-1:0] fb_addr_bus_i
);
	logic [7:0] rom_mem [0:65535];
	logic [`FB_DATA_W-1:0] pat = {8{16'h5A3C}};
	initial for (int a = 0; a < 65536; a++) rom_mem[a] = 8'(a) ^ 8'(a >> 8);
	// Undriven lines flip every cycle so stale values never look valid
	always @(posedge sys_clk) pat <= ~pat;
	assign fb_clock_return = fb_loopback_clock;
	// Strap resistors set every released address line; the reserved top line is pulled low
	assign fb_addr_bus_i = (fb_addr_bus & fb_addr_bus_oe) | ({1'b0, STRAP} & ~fb_addr_bus_oe);
	always @(posedge sys_clk) begin
		if (!boot_rom_select_n && !fb_data_bus_o[17]) rom_mem[fb_data_bus_o[15:0]] <= fb_data_bus_o[31:24];
	end
	always @* begin
		for (int i = 0; i < `FB_DATA_W; i++) fb_data_bus_i[i] = fb_data_bus_oe[i] ? fb_data_bus_o[i] : pat[i];
		if (!boot_rom_select_n && !fb_data_bus_o[16]) fb_data_bus_i[31:24] = rom_mem[fb_data_bus_o[15:0]];
	end
endmodule : fb_board_model

// *** sgram_framebuffer_port_with_rom_tb.sv ***
// Self-checking bench for the framebuffer memory port
`include "fb_port_cfg.svh"
module sgram_framebuffer_port_with_rom_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] STRAP_V = 10'h2A5;
	logic sys_clk = 0, nrst = 0, host_reset_n = 0, fb_mem_clk = 0, fb_clock_return;
	logic rom_req = 0, rom_write = 0, ram_req = 0, ram_row_strobe = 0, ram_col_strobe = 0, ram_write_strobe = 0;
	logic ram_drive = 0, ram_busy, ram_done, rom_busy, rom_done, boot_rom_select_n, fb_clock_gate;
	logic fb_row_strobe_n, fb_col_strobe_n, fb_write_strobe_n, fb_bank0_clock, fb_bank1_clock, fb_loopback_clock;
	logic [15:0] rom_addr = '0, ram_mask = '0, fb_byte_mask, cap_mask, a;
	logic [7:0] rom_wbyte = '0, rom_rbyte;
	logic [1:0] ram_bank = '0, fb_bank_select_n, seen_bank = '0;
	logic [9:0] ram_addr = '0, strap_value;
	logic [10:0] fb_addr_bus, cap_addr, fb_addr_bus_i, fb_addr_bus_oe;
	logic [127:0] ram_wdata = '0, ram_rdata, fb_data_bus_i, fb_data_bus_o, fb_data_bus_oe;
	logic [8:0] exp_q [$];
	logic [8:0] note;
	logic [128:0] ram_q [$];
	logic [128:0] rnote;
	logic [7:0] wr_mem [logic [15:0]];
	logic seen_row = 0;
	int seed = 33960, mismatches = 0, cmp_count = 0, ram_seen = 0, cycles = 0;
	fb_port DUT (.*);
	fb_board_model #(.STRAP(STRAP_V)) u_board (.*);
	always #25 sys_clk = ~sys_clk;
	initial begin
		#13;
		forever #80 fb_mem_clk = ~fb_mem_clk;
	end
	task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string name);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task stop_test;
		if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic wait_idle;
		for (int n = 0; n < 200 && (rom_busy !== 1'b0 || ram_busy !== 1'b0); n++) @(posedge sys_clk) #5;
		check(rom_busy | ram_busy, 1'b0, "busy");
	endtask : wait_idle
	// Unwritten ROM bytes read as the folded address
	task automatic rom_op(input logic wr, input logic [15:0] ad, input logic [7:0] b, input logic both);
		wait_idle();
		exp_q.push_back({!wr, wr_mem.exists(ad) ? wr_mem[ad] : ad[7:0] ^ ad[15:8]});
		if (wr) wr_mem[ad] = b;
		rom_write = wr;
		rom_addr = ad;
		rom_wbyte = b;
		rom_req = 1'b1;
		ram_req = both;
		@(posedge sys_clk) #5;
		rom_req = 1'b0;
		ram_req = 1'b0;
		for (int n = 0; n < 20 && rom_done !== 1'b1; n++) @(posedge sys_clk) #5;
		check(rom_done, 1'b1, "rom_done");
	endtask : rom_op
	task automatic ram_op(input logic [1:0] bk);
		wait_idle();
		ram_bank = bk;
		ram_addr = 10'($random(seed));
		ram_mask = 16'($random(seed));
		ram_wdata = {4{$random(seed)}};
		{ram_col_strobe, ram_write_strobe, ram_drive} = 3'($random(seed));
		ram_row_strobe = 1'b1;
		ram_q.push_back({ram_drive, ram_wdata});
		ram_req = 1'b1;
		@(posedge sys_clk) #5;
		ram_req = 1'b0;
		for (int n = 0; n < 60 && ram_done !== 1'b1; n++) @(posedge sys_clk) #5;
		check(ram_done, 1'b1, "ram_done");
		check(cap_mask, ram_mask, "fb_byte_mask");
		check(cap_addr, {1'b0, ram_addr}, "fb_addr_bus");
	endtask : ram_op
	// Result watcher: one note per finished ROM or RAM access
	always @(negedge sys_clk) begin
		if (rom_done === 1'b1) begin
			note = exp_q.pop_front();
			if (note[8]) check(rom_rbyte, note[7:0], "rom_rbyte");
		end
		if (ram_done === 1'b1) begin
			rnote = ram_q.pop_front();
			ram_seen++;
			if (rnote[128]) check(ram_rdata, rnote[127:0], "ram_rdata");
		end
	end
	always @(posedge fb_mem_clk) begin
		seen_bank <= seen_bank | ~fb_bank_select_n;
		seen_row <= seen_row | ~fb_row_strobe_n;
		if (fb_bank_select_n !== 2'b11) begin
			cap_mask <= fb_byte_mask;
			cap_addr <= fb_addr_bus;
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk) #5;
		nrst = 1'b1;
		repeat (4) @(posedge sys_clk) #5;
		check(fb_addr_bus_oe, 11'h000, "fb_addr_bus_oe");
		host_reset_n = 1'b1;
		repeat (6) @(posedge sys_clk) #5;
		check(strap_value, STRAP_V, "strap_value");
		check(fb_addr_bus_oe, 11'h7FF, "fb_addr_bus_oe");
		// ROM must win a same-cycle request and the RAM one is dropped
		rom_op(1'b0, 16'h0000, 8'h00, 1'b1);
		repeat (20) @(posedge sys_clk) #5;
		check(ram_seen, 0, "ram_done");
		for (int i = 0; i < 10; i++) begin
			a = 16'($random(seed));
			rom_op(1'b1, a, 8'($random(seed)), 1'b0);
			rom_op(1'b0, a, 8'h00, 1'b0);
			rom_op(1'b0, ~a, 8'h00, 1'b0);
		end
		for (int i = 0; i < 6; i++) ram_op(2'b01 << (i % 2));
		rom_op(1'b0, 16'hFFFF, 8'h00, 1'b0);
		repeat (4) @(posedge sys_clk) #5;
		check(seen_bank, 2'b11, "fb_bank_select_n");
		check(seen_row, 1'b1, "fb_row_strobe_n");
		check(ram_seen, 6, "ram_done");
		check(exp_q.size() + ram_q.size(), 0, "result queue");
		stop_test();
	end
endmodule : sgram_framebuffer_port_with_rom_tb
